// file: src/sfr_read_seq.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_read_seq #(
  parameter int AW         = 12,
  parameter int FIFO_DEPTH = 16
) (
  // system
  input wire logic          clk_sys,
  input wire logic          reset,
  // serial link pins
  input wire logic          sel_n,
  input wire logic          sclk,
  input wire logic [3:0]    serial_data_lines_i,
  output wire logic [3:0]   serial_data_lines_o,
  output wire logic [3:0]   serial_data_lines_oe,
  // configuration, same clock domain
  input wire logic [1:0]    cfg_proto,
  input wire logic          cfg_dtr_en,
  input wire logic          cfg_addr4_nv,
  input wire logic          addr4_enter,
  input wire logic          addr4_exit,
  input wire logic [4:0]    cfg_dummy,
  // array load port
  input wire logic          mem_we,
  input wire logic [AW-1:0] mem_waddr,
  input wire logic [7:0]    mem_wdata,
  // status
  output wire logic [AW-1:0] read_addr,
  output wire logic          busy
);
  typedef struct packed {
    sfr_pkg::sfr_state_t st;
    logic                cs1;
    logic                cs2;
    logic                ck1;
    logic                ck2;
    logic                ck3;
    logic [3:0]          dq1;
    logic [3:0]          dq2;
    logic [31:0]         sh;
    logic [5:0]          cnt;
    logic [2:0]          lines;
    logic [2:0]          dl;
    logic                dtr;
    logic                wide;
    logic [4:0]          dum;
    logic [7:0]          ob;
    logic [3:0]          obits;
    logic [AW-1:0]       cur;
    logic [AW-1:0]       pf;
    logic                pend;
    logic [3:0]          dq_o;
    logic [3:0]          dq_oe;
    logic                a4m;
    logic                init;
    logic                busy;
  } sfr_top_st_t;

  sfr_top_st_t       r;
  sfr_top_st_t       n;
  sfr_pkg::sfr_dec_t dec;
  logic              rise;
  logic              fall;
  logic              smp;
  logic              addr_head;
  logic              drv;
  logic              cmd_last;
  logic              addr_last;
  logic              ignore;
  logic [2:0]        pl;
  logic [31:0]       nsh;
  logic [31:0]       addr_cap;
  logic [7:0]        rd_byte;
  logic              issue;
  logic              pop;
  logic              flush;
  logic [7:0]        out_byte;

  sfr_strm_if #(.W(8)) fin ();
  sfr_strm_if #(.W(8)) fout ();

  function automatic logic [2:0] wid(input logic [2:0] a, input logic [2:0] b);
    return (a > b) ? a : b;
  endfunction

  // shift in, first bit lands highest
  function automatic logic [31:0] shin(input logic [31:0] s, input logic [3:0] d,
                                       input logic [2:0] l);
    case (l)
      sfr_pkg::L4: shin = {s[27:0], d};
      sfr_pkg::L2: shin = {s[29:0], d[1:0]};
      default: shin = {s[30:0], d[0]};
    endcase
  endfunction

  // single-line output goes out on line 1
  function automatic logic [3:0] drive(input logic [7:0] b, input logic [2:0] l);
    case (l)
      sfr_pkg::L4: drive = b[7:4];
      sfr_pkg::L2: drive = {2'b00, b[7:6]};
      default: drive = {2'b00, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] oe_mask(input logic [2:0] l);
    case (l)
      sfr_pkg::L4: oe_mask = 4'hf;
      sfr_pkg::L2: oe_mask = 4'h3;
      default: oe_mask = 4'h2;
    endcase
  endfunction

  function automatic sfr_pkg::sfr_dec_t sfr_decode(input logic [7:0] op);
    sfr_pkg::sfr_dec_t d;
    d = '0;
    d.ok = 1'b1;
    d.al = sfr_pkg::L1;
    d.dl = sfr_pkg::L1;
    case (op)
      sfr_pkg::OP_READ, sfr_pkg::OP4_READ: begin
        d.nodum = 1'b1;
      end
      sfr_pkg::OP_FAST, sfr_pkg::OP4_FAST, sfr_pkg::OP_DTR_FAST,
      sfr_pkg::OP4_DTR_FAST: begin
        d.dl = sfr_pkg::L1;
      end
      sfr_pkg::OP_DOFR, sfr_pkg::OP4_DOFR, sfr_pkg::OP_DTR_DOFR: begin
        d.dl = sfr_pkg::L2;
      end
      sfr_pkg::OP_DIOFR, sfr_pkg::OP4_DIOFR, sfr_pkg::OP_DTR_DIOFR,
      sfr_pkg::OP4_DTR_DIOFR: begin
        d.al = sfr_pkg::L2;
        d.dl = sfr_pkg::L2;
      end
      sfr_pkg::OP_QOFR, sfr_pkg::OP4_QOFR, sfr_pkg::OP_DTR_QOFR: begin
        d.dl = sfr_pkg::L4;
      end
      sfr_pkg::OP_QIOFR, sfr_pkg::OP4_QIOFR, sfr_pkg::OP_DTR_QIOFR,
      sfr_pkg::OP4_DTR_QIOFR, sfr_pkg::OP_WORD: begin
        d.al = sfr_pkg::L4;
        d.dl = sfr_pkg::L4;
      end
      default: begin
        d.ok = 1'b0;
      end
    endcase
    d.word = (op == sfr_pkg::OP_WORD);
    d.a4 = op inside {sfr_pkg::OP4_READ, sfr_pkg::OP4_FAST, sfr_pkg::OP4_DOFR,
                      sfr_pkg::OP4_DIOFR, sfr_pkg::OP4_QOFR, sfr_pkg::OP4_QIOFR,
                      sfr_pkg::OP4_DTR_FAST, sfr_pkg::OP4_DTR_DIOFR,
                      sfr_pkg::OP4_DTR_QIOFR};
    d.dtr = op inside {sfr_pkg::OP_DTR_FAST, sfr_pkg::OP_DTR_DOFR, sfr_pkg::OP_DTR_DIOFR,
                       sfr_pkg::OP_DTR_QOFR, sfr_pkg::OP_DTR_QIOFR, sfr_pkg::OP4_DTR_FAST,
                       sfr_pkg::OP4_DTR_DIOFR, sfr_pkg::OP4_DTR_QIOFR};
    return d;
  endfunction

  // link edges from the synchronised clock copy
  assign rise      = r.ck2 && !r.ck3;
  assign fall      = !r.ck2 && r.ck3;
  // address opens on a rise: skip the fall that ends a single-rate command
  assign addr_head = (r.st == sfr_pkg::S_ADDR)
                     && (r.cnt == (r.wide ? sfr_pkg::ADDR4_BITS : sfr_pkg::ADDR3_BITS));
  assign smp       = rise || (r.dtr && fall && !addr_head);
  assign drv       = fall || (r.dtr && rise);
  assign pl        = (cfg_proto == sfr_pkg::PROTO_QUAD) ? sfr_pkg::L4 :
                     (cfg_proto == sfr_pkg::PROTO_DUAL) ? sfr_pkg::L2 : sfr_pkg::L1;
  assign nsh       = shin(r.sh, r.dq2, r.lines);
  assign dec       = sfr_decode(nsh[7:0]);
  assign cmd_last  = (r.st == sfr_pkg::S_CMD) && smp && (r.cnt == {3'h0, r.lines});
  assign addr_last = (r.st == sfr_pkg::S_ADDR) && smp && (r.cnt == {3'h0, r.lines});
  assign ignore    = !dec.ok || (dec.word && ((cfg_proto == sfr_pkg::PROTO_DUAL)
                     || cfg_dtr_en));
  assign addr_cap  = r.wide ? nsh : {8'h00, nsh[23:0]};
  assign out_byte  = fout.valid ? fout.data : sfr_pkg::FILL_BYTE;

  // prefetch: one read in flight, fifo room is checked before issue
  assign issue     = ((r.st == sfr_pkg::S_DUMMY) || (r.st == sfr_pkg::S_DATA))
                     && !r.pend && fin.ready;
  assign flush     = (r.st == sfr_pkg::S_IDLE);
  assign pop       = (r.st == sfr_pkg::S_DATA) && drv && (r.obits == 4'h0)
                     && fout.valid && !r.cs2;
  assign fin.valid = r.pend;
  assign fin.data  = rd_byte;
  assign fout.ready = pop;

  always_comb begin
    n = r;
    n.cs1 = sel_n;
    n.cs2 = r.cs1;
    n.ck1 = sclk;
    n.ck2 = r.ck1;
    n.ck3 = r.ck2;
    n.dq1 = serial_data_lines_i;
    n.dq2 = r.dq1;
    n.busy = (r.st != sfr_pkg::S_IDLE);
    n.init = 1'b1;
    n.pend = issue;
    // strap caught after release, then the mode commands rule
    if (!r.init) begin
      n.a4m = cfg_addr4_nv;
    end else if (addr4_enter) begin
      n.a4m = 1'b1;
    end else if (addr4_exit) begin
      n.a4m = 1'b0;
    end
    if (issue) begin
      n.pf = r.pf + 1'b1;
    end
    case (r.st)
      sfr_pkg::S_IDLE: begin
        if (!r.cs2) begin
          n.st = sfr_pkg::S_CMD;
          n.cnt = sfr_pkg::CMD_BITS;
          n.lines = pl;
          n.dtr = cfg_dtr_en;
        end
      end
      sfr_pkg::S_CMD: begin
        if (smp) begin
          n.sh = nsh;
          n.cnt = r.cnt - {3'h0, r.lines};
        end
        if (cmd_last) begin
          if (ignore) begin
            n.st = sfr_pkg::S_IGNORE;
          end else begin
            n.st = sfr_pkg::S_ADDR;
            n.wide = dec.a4 || r.a4m;
            n.cnt = (dec.a4 || r.a4m) ? sfr_pkg::ADDR4_BITS : sfr_pkg::ADDR3_BITS;
            n.lines = wid(dec.al, pl);
            n.dl = wid(dec.dl, pl);
            n.dtr = dec.dtr || cfg_dtr_en;
            n.dum = dec.nodum ? 5'h00 : dec.word ? sfr_pkg::WORD_DUMMY : cfg_dummy;
          end
        end
      end
      sfr_pkg::S_ADDR: begin
        if (smp) begin
          n.sh = nsh;
          n.cnt = r.cnt - {3'h0, r.lines};
        end
        if (addr_last) begin
          n.cur = addr_cap[AW-1:0];
          n.pf = addr_cap[AW-1:0];
          n.obits = 4'h0;
          n.st = (r.dum == 5'h00) ? sfr_pkg::S_DATA : sfr_pkg::S_DUMMY;
        end
      end
      sfr_pkg::S_DUMMY: begin
        if (rise) begin
          n.dum = r.dum - 5'h01;
          if (r.dum == 5'h01) begin
            n.st = sfr_pkg::S_DATA;
          end
        end
      end
      sfr_pkg::S_DATA: begin
        if (drv) begin
          n.dq_oe = oe_mask(r.dl);
          if (r.obits == 4'h0) begin
            // an empty fifo sends filler rather than stalling the link
            n.dq_o = drive(out_byte, r.dl);
            n.ob = out_byte << r.dl;
            n.obits = sfr_pkg::BYTE_BITS - {1'b0, r.dl};
            if (pop) begin
              n.cur = r.cur + 1'b1;
            end
          end else begin
            n.dq_o = drive(r.ob, r.dl);
            n.ob = r.ob << r.dl;
            n.obits = r.obits - {1'b0, r.dl};
          end
        end
      end
      sfr_pkg::S_IGNORE: begin
        n.st = sfr_pkg::S_IGNORE;
      end
      default: begin
        n.st = sfr_pkg::S_IDLE;
      end
    endcase
    if (r.cs2) begin
      n.st = sfr_pkg::S_IDLE;
      n.dq_oe = 4'h0;
      n.obits = 4'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '{st: sfr_pkg::S_IDLE, cs1: 1'b1, cs2: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  sfr_mem #(.AW(AW), .DW(8)) u_mem (
    .clk_sys (clk_sys),
    .reset   (reset),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .re      (issue),
    .raddr   (r.pf),
    .rdata   (rd_byte)
  );

  sfr_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .reset   (reset),
    .flush   (flush),
    .wr      (fin),
    .rd      (fout)
  );

  assign serial_data_lines_o  = r.dq_o;
  assign serial_data_lines_oe = r.dq_oe;
  assign read_addr            = r.cur;
  assign busy                 = r.busy;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_cmd_done(logic [7:0] code);
    cmd_last && (nsh[7:0] == code);
  endsequence

  sequence s_first_load;
    (r.st == sfr_pkg::S_DATA) && drv && (r.obits == 4'h0) && fout.valid && !r.cs2;
  endsequence

  property p_abort;
    r.cs2 |=> (r.dq_oe == 4'h0) && (r.st == sfr_pkg::S_IDLE);
  endproperty
  a_abort: assert property (p_abort)
    else $error("data lines still driven after deselect");

  property p_oe_data;
    (r.dq_oe != 4'h0) |-> (r.st == sfr_pkg::S_DATA);
  endproperty
  a_oe_data: assert property (p_oe_data)
    else $error("data lines driven outside data phase");

  property p_addr3;
    s_cmd_done(sfr_pkg::OP_READ) and (!r.a4m) |=>
      (r.st == sfr_pkg::S_ADDR) && (r.cnt == sfr_pkg::ADDR3_BITS) && !r.wide;
  endproperty
  a_addr3: assert property (p_addr3)
    else $error("read did not take a 24-bit address");

  property p_addr4;
    s_cmd_done(sfr_pkg::OP4_READ) |=> (r.cnt == sfr_pkg::ADDR4_BITS) && r.wide;
  endproperty
  a_addr4: assert property (p_addr4)
    else $error("four-byte opcode did not take 32 address bits");

  property p_dtr_ded;
    s_cmd_done(sfr_pkg::OP_DTR_FAST) |=> r.dtr && (r.st == sfr_pkg::S_ADDR);
  endproperty
  a_dtr_ded: assert property (p_dtr_ded)
    else $error("double-rate opcode not in double rate");

  property p_quad_io;
    s_cmd_done(sfr_pkg::OP_QIOFR) |=> (r.lines == sfr_pkg::L4) && (r.dl == sfr_pkg::L4);
  endproperty
  a_quad_io: assert property (p_quad_io)
    else $error("quad io read not on four lines");

  property p_word_dual;
    s_cmd_done(sfr_pkg::OP_WORD) and (cfg_proto == sfr_pkg::PROTO_DUAL) |=>
      (r.st == sfr_pkg::S_IGNORE) ##1 (r.dq_oe == 4'h0);
  endproperty
  a_word_dual: assert property (p_word_dual)
    else $error("word read accepted in dual protocol");

  property p_word_dummy;
    s_cmd_done(sfr_pkg::OP_WORD) and (cfg_proto != sfr_pkg::PROTO_DUAL) and !cfg_dtr_en
      |=> (r.dum == sfr_pkg::WORD_DUMMY);
  endproperty
  a_word_dummy: assert property (p_word_dummy)
    else $error("word read dummy count not four");

  property p_incr;
    s_first_load |=> (r.cur == AW'($past(r.cur) + 1'b1));
  endproperty
  a_incr: assert property (p_incr)
    else $error("read address not advanced by one byte");

  property p_msb;
    s_first_load and (r.dl == sfr_pkg::L1) |=> (r.dq_o[1] == $past(fout.data[7]));
  endproperty
  a_msb: assert property (p_msb)
    else $error("first output bit is not the byte msb");

  property p_rise_only;
    (r.st == sfr_pkg::S_ADDR) && !r.dtr && !rise && !r.cs2 |=> $stable(r.sh);
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("address shifted without a rising clock");
endmodule
`default_nettype wire

// file: src/sfr_pkg.sv
package sfr_pkg;

  // three-byte (or mode addressed) read opcodes
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST       = 8'h0b;
  localparam logic [7:0] OP_DOFR       = 8'h3b;
  localparam logic [7:0] OP_DIOFR      = 8'hbb;
  localparam logic [7:0] OP_QOFR       = 8'h6b;
  localparam logic [7:0] OP_QIOFR      = 8'heb;
  localparam logic [7:0] OP_WORD       = 8'he7;
  localparam logic [7:0] OP_DTR_FAST   = 8'h0d;
  localparam logic [7:0] OP_DTR_DOFR   = 8'h3d;
  localparam logic [7:0] OP_DTR_DIOFR  = 8'hbd;
  localparam logic [7:0] OP_DTR_QOFR   = 8'h6d;
  localparam logic [7:0] OP_DTR_QIOFR  = 8'hed;
  // dedicated four-byte opcodes
  localparam logic [7:0] OP4_READ      = 8'h13;
  localparam logic [7:0] OP4_FAST      = 8'h0c;
  localparam logic [7:0] OP4_DOFR      = 8'h3c;
  localparam logic [7:0] OP4_DIOFR     = 8'hbc;
  localparam logic [7:0] OP4_QOFR      = 8'h6c;
  localparam logic [7:0] OP4_QIOFR     = 8'hec;
  localparam logic [7:0] OP4_DTR_FAST  = 8'h0e;
  localparam logic [7:0] OP4_DTR_DIOFR = 8'hbe;
  localparam logic [7:0] OP4_DTR_QIOFR = 8'hee;

  // protocol select and line counts
  localparam logic [1:0] PROTO_EXT  = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;
  localparam logic [2:0] L1         = 3'h1;
  localparam logic [2:0] L2         = 3'h2;
  localparam logic [2:0] L4         = 3'h4;

  // phase lengths and filler byte
  localparam logic [5:0] CMD_BITS   = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [4:0] WORD_DUMMY = 5'h04;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [7:0] FILL_BYTE  = 8'hff;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_CMD    = 3'b001,
    S_ADDR   = 3'b010,
    S_DUMMY  = 3'b011,
    S_DATA   = 3'b100,
    S_IGNORE = 3'b101
  } sfr_state_t;

  typedef struct packed {
    logic       ok;
    logic       a4;
    logic       dtr;
    logic [2:0] al;
    logic [2:0] dl;
    logic       nodum;
    logic       word;
  } sfr_dec_t;

endpackage

// file: src/sfr_strm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfr_strm_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: src/sfr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic     clk_sys,
  input wire logic     reset,
  // drop all content
  input wire logic     flush,
  // streams
  sfr_strm_if.snk      wr,
  sfr_strm_if.src      rd
);
  // pointers wrap by overflow, so depth must be a power of two
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } sfr_fifo_st_t;

  sfr_fifo_st_t r;
  sfr_fifo_st_t n;
  logic         push;
  logic         pop;

  assign wr.ready = (r.cnt != (PW+1)'(DEPTH));
  assign rd.valid = (r.cnt != '0);
  assign rd.data  = r.mem[r.rp];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = wr.data;
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// file: src/sfr_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic          clk_sys,
  input wire logic          reset,
  // write port
  input wire logic          we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port, one cycle latency
  input wire logic          re,
  input wire logic [AW-1:0] raddr,
  output var logic [DW-1:0] rdata
);
  logic [DW-1:0] arr [2**AW];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      arr[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= arr[raddr];
    end
  end
endmodule
`default_nettype wire

// file: tb/sfr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  // link pins
  output var logic       sel_n,
  output var logic       sclk,
  output var logic [3:0] drv,
  // device drive
  input wire logic [3:0] dq_o,
  input wire logic [3:0] dq_oe
);
  logic [3:0] lvl;

  // device wins the pin wherever it drives
  assign lvl = (dq_oe & dq_o) | (~dq_oe & drv);

  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    drv   = 4'h0;
  end

  // data moves mid half period, clear of both edges after resync
  task automatic edge_x(input logic [3:0] d, output logic [3:0] q);
    #40 drv = d;
    #22.5 q = lvl;
    sclk = ~sclk;
  endtask

  task automatic send(input logic [31:0] v, input int nb, input int ln, input bit dtr);
    logic [3:0] q;
    for (int i = nb - ln; i >= 0; i -= ln) begin
      edge_x(4'(v >> i) & 4'(2 ** ln - 1), q);
      if (!dtr) edge_x(drv, q);
    end
  endtask

  task automatic xact(input logic [7:0] op, input logic [31:0] ad, input int cl, input int al,
                      input int dl, input bit cdtr, input bit adtr, input bit a4,
                      input int nd, input int nb, input int tail,
                      output logic [7:0] q[$], output logic [3:0] oes);
    logic [3:0] s;
    logic [7:0] b;
    q = {};
    b = 8'h00;
    oes = 4'h0;
    sel_n = 1'b0;
    send({24'h000000, op}, 8, cl, cdtr);
    send(ad, a4 ? 32 : 24, al, adtr);
    repeat (2 * nd) edge_x(drv, s);
    repeat (nb) begin
      for (int k = 0; k < 8 / dl; k++) begin
        // released lines never show the last driven value
        edge_x(~drv, s);
        oes = dq_oe;
        b = 8'((b << dl) | (dl == 1 ? 4'(s[1]) : s & 4'(2 ** dl - 1)));
        if (!adtr) edge_x(~drv, s);
      end
      q.push_back(b);
    end
    repeat (tail) edge_x(~drv, s);
    #40 sel_n = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// file: tb/test_serial_flash_read_commands.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_read_commands;
  localparam int AW    = 12;
  localparam int LIMIT = 80000;
  // stimulus
  logic          clk_sys     = 1'b0;
  logic          reset       = 1'b1;
  logic [1:0]    cfg_proto   = 2'h0;
  logic          cfg_dtr_en  = 1'b0;
  logic          addr4_enter = 1'b0;
  logic          cfg_addr4_nv = 1'b0;
  logic          addr4_exit  = 1'b0;
  logic [4:0]    cfg_dummy   = 5'h08;
  logic          mem_we      = 1'b0;
  logic [AW-1:0] mem_waddr   = 12'h000;
  logic [7:0]    mem_wdata   = 8'h00;
  // pins and status
  wire logic          sel_n;
  wire logic          sclk;
  wire logic          busy;
  wire logic [3:0]    drv;
  wire logic [3:0]    dq_o;
  wire logic [3:0]    dq_oe;
  wire logic [AW-1:0] read_addr;
  // reference model
  logic [7:0]  mem_m [4096];
  logic [31:0] seed = 32'h0000003f;
  logic        a4m  = 1'b0;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  // opcode, address lines, data lines, flags (bit0 double rate, bit1 four-byte)
  logic [19:0] tab [21] = '{20'h03110, 20'h0b110, 20'h3b120, 20'hbb220, 20'h6b140,
    20'heb440, 20'he7440, 20'h0d111, 20'h3d121, 20'hbd221, 20'h6d141, 20'hed441,
    20'h13112, 20'h0c112, 20'h3c122, 20'hbc222, 20'h6c142, 20'hec442, 20'h0e113,
    20'hbe223, 20'hee443};

  sfr_read_seq #(.AW(AW), .FIFO_DEPTH(16)) sfr_read_seq_inst (
    .clk_sys(clk_sys), .reset(reset), .sel_n(sel_n), .sclk(sclk),
    .serial_data_lines_i((dq_oe & dq_o) | (~dq_oe & drv)),
    .serial_data_lines_o(dq_o), .serial_data_lines_oe(dq_oe),
    .cfg_proto(cfg_proto), .cfg_dtr_en(cfg_dtr_en), .cfg_addr4_nv(cfg_addr4_nv),
    .addr4_enter(addr4_enter), .addr4_exit(addr4_exit), .cfg_dummy(cfg_dummy),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .read_addr(read_addr), .busy(busy));

  sfr_host_model sfr_host_model_inst (
    .sel_n(sel_n), .sclk(sclk), .drv(drv), .dq_o(dq_o), .dq_oe(dq_oe));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_nib(input string n, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_addr(input string n, input logic [AW-1:0] e, input logic [AW-1:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic setcfg(input logic [1:0] p, input logic d);
    @(posedge clk_sys);
    #1 cfg_proto = p;
    cfg_dtr_en = d;
  endtask

  task automatic run(input int idx, input logic [31:0] ad, input int nb, input int tail);
    logic [7:0] op;
    logic [7:0] q[$];
    logic [3:0] oes;
    logic [3:0] ex;
    int         pl;
    int         al;
    int         dl;
    int         nd;
    bit         refd;
    op = tab[idx][19:12];
    pl = cfg_proto == 2'h0 ? 1 : (cfg_proto == 2'h1 ? 2 : 4);
    al = int'(tab[idx][11:8]) > pl ? int'(tab[idx][11:8]) : pl;
    dl = int'(tab[idx][7:4]) > pl ? int'(tab[idx][7:4]) : pl;
    nd = (op == 8'h03 || op == 8'h13) ? 0 : (op == 8'he7 ? 4 : int'(cfg_dummy));
    refd = op == 8'he7 && (cfg_proto == 2'h1 || cfg_dtr_en == 1'b1);
    sfr_host_model_inst.xact(op, ad, pl, al, dl, cfg_dtr_en, tab[idx][0] | cfg_dtr_en,
                             tab[idx][1] | a4m, nd, nb, tail, q, oes);
    ex = refd ? 4'h0 : (dl == 1 ? 4'h2 : (dl == 2 ? 4'h3 : 4'hf));
    chk_nib("output enable", ex, oes);
    for (int i = 0; i < nb && !refd; i++) begin
      chk_byte("read byte", mem_m[12'(ad + 32'(i))], q[i]);
    end
    chk_nib("enable after deselect", 4'h0, dq_oe);
    // the edge after the last bit already loads the following byte
    if (!refd) chk_addr("read address", 12'(ad + 32'(nb + 1)), read_addr);
    chk_nib("busy after deselect", 4'h0, {3'h0, busy});
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    #1 reset = 1'b0;
    for (int i = 0; i < 4096; i++) begin
      @(posedge clk_sys);
      #1 mem_we = 1'b1;
      mem_waddr = 12'(i);
      mem_wdata = 8'(rnd());
      mem_m[i] = mem_wdata;
    end
    @(posedge clk_sys);
    #1 mem_we = 1'b0;
    #100;
    // every opcode, random dummy count and start address; word read kept even
    for (int i = 0; i < 21; i++) begin
      @(posedge clk_sys);
      #1 cfg_dummy = 5'(1 + rnd() % 15);
      run(i, rnd() & (i == 6 ? 32'hfffffffe : 32'hffffffff), 3, 0);
    end
    run(0, 32'h00abcfff, 3, 0);
    run(12, 32'h12345fff, 2, 0);
    setcfg(2'h2, 1'b0);
    run(1, rnd(), 2, 0);
    run(6, rnd() & 32'hfffffffe, 2, 0);
    setcfg(2'h1, 1'b0);
    run(1, rnd(), 2, 0);
    run(6, rnd() & 32'hfffffffe, 1, 0);
    setcfg(2'h0, 1'b1);
    run(6, rnd() & 32'hfffffffe, 1, 0);
    setcfg(2'h0, 1'b0);
    @(posedge clk_sys);
    #1 addr4_enter = 1'b1;
    @(posedge clk_sys);
    #1 addr4_enter = 1'b0;
    a4m = 1'b1;
    run(1, rnd(), 2, 0);
    run(3, rnd(), 2, 0);
    @(posedge clk_sys);
    #1 addr4_exit = 1'b1;
    @(posedge clk_sys);
    #1 addr4_exit = 1'b0;
    a4m = 1'b0;
    run(1, rnd(), 2, 0);
    // deselect in mid byte, then a clean read must follow
    run(1, rnd(), 1, 4);
    run(0, rnd(), 2, 0);
    // second reset with the four-byte strap set
    @(posedge clk_sys);
    #1 reset = 1'b1;
    cfg_addr4_nv = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    a4m = 1'b1;
    repeat (3) @(posedge clk_sys);
    run(1, rnd(), 2, 0);
    summarize();
  end
endmodule
`default_nettype wire
